// [com_consts.vh]
`ifndef COM_CONSTS_VH
`define COM_CONSTS_VH

// Timing.
`define COM_CLK_HZ 20000000
`define COM_CLK_KHZ (`COM_CLK_HZ / 1000)
`define COM_FIRST_WAKE_MS 500
`define COM_FIRST_WAKE_CYC (`COM_FIRST_WAKE_MS * `COM_CLK_KHZ)

// Register byte offsets.
`define COM_CTRL_OFS 4'h0
`define COM_STATUS_OFS 4'h4

// Control register fields.
`define COM_CTRL_LATCH_OFF 0
`define COM_CTRL_AUX_EN 1
`define COM_CTRL_CHG_DIS 2
`define COM_CTRL_RST 3'h0

// Status register fields.
`define COM_ST_MODE_LSB 0
`define COM_ST_BAT_FET 3
`define COM_ST_SYS_IN 4
`define COM_ST_CHARGING 5
`define COM_ST_OCP 6
`define COM_ST_BAT_OK 7
`define COM_ST_WDOG 8

// Pin input vector positions and their idle levels.
`define COM_PIN_W 12
`define COM_P_IN_UVLO 0
`define COM_P_IN_OVP 1
`define COM_P_IN_SLEEP 2
`define COM_P_IN_DPM 3
`define COM_P_BAT_UV 4
`define COM_P_BAT_UV_HYS 5
`define COM_P_BAT_MAX 6
`define COM_P_BAT_PRES 7
`define COM_P_BAT_OC 8
`define COM_P_PB_N 9
`define COM_P_LP_N 10
`define COM_P_CE_N 11
`define COM_PIN_RST 12'hE00

`endif

// [com_mode_ctrl.v]
`include "com_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Latched-off holds until input or long press
// - Latch-off entry ignores charge enable input
// - Battery only, no input: latch off unless pressed
// - Latch-off request waits for input removal
// - Latch-off request waits for button release
// - Button wake from latch-off needs battery above highest threshold
// - Host clearing request cancels pending latch-off
// - Watchdog expiry keeps latch-off request set
// - Low-power entry needs select low, idle
// - Low power: rail from battery, bus off
// - Aux output keeps enable state in low power
// - Leave low power on select high or input
// - Overvoltage input with select low: active battery
// - Button low in low power gives active battery
// - Battery mode with good battery: discharge FET on
// - Over-current turns discharge FET off in battery mode
// - Battery undervoltage cutoff with fixed hysteresis
// - Input valid: charge mode, rail and charging
// - Rail from input only above margin, below overvoltage
// - Battery insertion probes button, then wake timer
// - Functions gated per operating mode
module com_mode_ctrl #(
   parameter WAKE_CYC = `COM_FIRST_WAKE_CYC,
   parameter WAKE_W = 24
) (
   // Clock, reset and clock enable.
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   // Analog comparator results and pins, asynchronous.
   input wire in_above_uvlo,
   input wire in_above_ovp,
   input wire in_above_sleep,
   input wire in_above_dpm,
   input wire bat_above_uvlo,
   input wire bat_above_uvlo_hyst,
   input wire bat_above_max_uvlo,
   input wire bat_present,
   input wire bat_overcurrent,
   input wire pushbutton_n,
   input wire low_power_select_n,
   input wire charge_enable_n,
   // Same-clock status from neighbouring logic.
   input wire charge_done,
   input wire irq_pending,
   input wire wdog_expired,
   // Avalon-MM slave.
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output wire [31:0] readdata,
   output wire waitrequest,
   // Mode and power control outputs.
   output wire [2:0] mode,
   output wire vdd_enable,
   output wire vdd_from_battery,
   output wire osc_enable,
   output wire serial_enable,
   output wire irq_enable,
   output wire bat_fet_on,
   output wire system_rail_from_input,
   output wire charge_active,
   output wire aux_output_on
);

   localparam [2:0] ST_SHIP = 3'h0;
   localparam [2:0] ST_LP = 3'h1;
   localparam [2:0] ST_ACTBAT = 3'h2;
   localparam [2:0] ST_CHARGE = 3'h3;
   localparam [2:0] ST_PROBE = 3'h4;
   localparam [2:0] ST_WAKE = 3'h5;
   // The count is cut to the counter width on purpose; WAKE_W must hold WAKE_CYC.
   localparam [31:0] WAKE_CYC_32 = WAKE_CYC;
   localparam [WAKE_W-1:0] WAKE_LIM = WAKE_CYC_32[WAKE_W-1:0];

   function is_bus_mode;
      input [2:0] st;
      begin
         is_bus_mode = (st == ST_CHARGE) || (st == ST_ACTBAT);
      end
   endfunction

   function is_clocked_mode;
      input [2:0] st;
      begin
         is_clocked_mode = (st != ST_SHIP) && (st != ST_LP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree.

   wire [`COM_PIN_W-1:0] pins_raw;
   reg [`COM_PIN_W-1:0] sync1_ff;
   reg [`COM_PIN_W-1:0] sync2_ff;
   reg [`COM_PIN_W-1:0] sync3_ff;
   reg [`COM_PIN_W-1:0] pin_ff;
   reg bat_pres_d_ff;

   assign pins_raw = {charge_enable_n, low_power_select_n, pushbutton_n, bat_overcurrent,
                      bat_present, bat_above_max_uvlo, bat_above_uvlo_hyst, bat_above_uvlo,
                      in_above_dpm, in_above_sleep, in_above_ovp, in_above_uvlo};

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= `COM_PIN_RST;
         sync2_ff <= `COM_PIN_RST;
         sync3_ff <= `COM_PIN_RST;
         pin_ff <= `COM_PIN_RST;
         bat_pres_d_ff <= 1'b0;
      end else if (clk_en) begin
         sync1_ff <= pins_raw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pin_ff <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));
         bat_pres_d_ff <= pin_ff[`COM_P_BAT_PRES];
      end
   end

   wire in_uvlo_ok = pin_ff[`COM_P_IN_UVLO];
   wire in_ovp = pin_ff[`COM_P_IN_OVP];
   wire pb_n = pin_ff[`COM_P_PB_N];
   wire lp_n = pin_ff[`COM_P_LP_N];
   wire bat_insert = pin_ff[`COM_P_BAT_PRES] & ~bat_pres_d_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon slave: one wait state, then the answer edge.

   reg waitreq_ff;
   reg [31:0] readdata_ff;
   reg [2:0] ctrl_ff;
   reg wdog_seen_ff;
   reg [2:0] state_ff;
   reg bat_fet_ff;
   reg sys_in_ff;
   reg chg_ff;
   reg ocp_ff;
   reg bat_ok_ff;
   reg vdd_en_ff;
   reg vdd_bat_ff;
   reg osc_ff;
   reg ser_ff;
   reg irq_en_ff;
   reg aux_ff;
   reg [WAKE_W-1:0] wake_cnt_ff;
   reg from_ship_ff;
   reg [2:0] nxt_state;
   reg [31:0] nxt_rdata;

   wire bus_req = read | write;
   wire bus_busy = bus_req | ~waitreq_ff;
   wire bus_wr = write & ~waitreq_ff & ser_ff;
   wire wr_ctrl = bus_wr && (address == `COM_CTRL_OFS);
   wire wr_status = bus_wr && (address == `COM_STATUS_OFS);

   always @* begin
      nxt_rdata = 32'h00000000;
      if (ser_ff && address == `COM_CTRL_OFS) begin
         nxt_rdata[2:0] = ctrl_ff;
      end else if (ser_ff && address == `COM_STATUS_OFS) begin
         nxt_rdata[`COM_ST_MODE_LSB+2:`COM_ST_MODE_LSB] = state_ff;
         nxt_rdata[`COM_ST_BAT_FET] = bat_fet_ff;
         nxt_rdata[`COM_ST_SYS_IN] = sys_in_ff;
         nxt_rdata[`COM_ST_CHARGING] = chg_ff;
         nxt_rdata[`COM_ST_OCP] = ocp_ff;
         nxt_rdata[`COM_ST_BAT_OK] = bat_ok_ff;
         nxt_rdata[`COM_ST_WDOG] = wdog_seen_ff;
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         waitreq_ff <= 1'b1;
         readdata_ff <= 32'h00000000;
      end else if (clk_en) begin
         if (bus_req && waitreq_ff) begin
            waitreq_ff <= 1'b0;
            readdata_ff <= read ? nxt_rdata : 32'h00000000;
         end else begin
            waitreq_ff <= 1'b1;
         end
      end
   end

   // Writes are dropped while the serial interface is gated off; the bus still
   // answers so that a master is never hung.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= `COM_CTRL_RST;
         wdog_seen_ff <= 1'b0;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_ff <= writedata[2:0];
         end else if (state_ff != ST_SHIP && nxt_state == ST_SHIP) begin
            ctrl_ff[`COM_CTRL_LATCH_OFF] <= 1'b0;
         end else if (wdog_expired) begin
            // Watchdog restores the charge setting only.
            ctrl_ff[`COM_CTRL_CHG_DIS] <= 1'b0;
         end
         if (wdog_expired) begin
            wdog_seen_ff <= 1'b1;
         end else if (wr_status && writedata[`COM_ST_WDOG]) begin
            wdog_seen_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mode state machine.

   wire latch_req = ctrl_ff[`COM_CTRL_LATCH_OFF];
   wire wake_done = (wake_cnt_ff >= WAKE_LIM);
   // Low power is left at once on select high or a press, but a bus
   // access or interrupt begun in an awake mode must finish first.
   wire lp_ok = ~lp_n & pb_n & ((state_ff == ST_LP) | (~bus_busy & ~irq_pending));

   always @* begin
      nxt_state = state_ff;
      if (in_uvlo_ok && state_ff != ST_SHIP || in_uvlo_ok && !in_ovp) begin
         // Input insertion wins over every battery-only transition.
         if (in_ovp && !lp_n) begin
            nxt_state = ST_ACTBAT;
         end else begin
            nxt_state = ST_CHARGE;
         end
      end else if (in_uvlo_ok) begin
         nxt_state = ST_ACTBAT;
      end else if (bat_insert) begin
         nxt_state = ST_PROBE;
      end else begin
         case (state_ff)
            ST_PROBE: begin
               nxt_state = pb_n ? ST_SHIP : ST_WAKE;
            end
            ST_SHIP: begin
               if (!pb_n && pin_ff[`COM_P_BAT_MAX]) begin
                  nxt_state = ST_WAKE;
               end
            end
            ST_WAKE: begin
               if (from_ship_ff && pb_n) begin
                  nxt_state = wake_done ? ST_ACTBAT : ST_SHIP;
               end else if (!from_ship_ff && wake_done) begin
                  nxt_state = ST_ACTBAT;
               end else if (!from_ship_ff && pb_n) begin
                  nxt_state = ST_SHIP;
               end
            end
            ST_CHARGE, ST_ACTBAT, ST_LP: begin
               // Charge enable plays no part in this decision.
               if (latch_req && pb_n) begin
                  nxt_state = ST_SHIP;
               end else if (lp_ok) begin
                  nxt_state = ST_LP;
               end else begin
                  nxt_state = ST_ACTBAT;
               end
            end
            default: begin
               nxt_state = ST_SHIP;
            end
         endcase
      end
   end

   // Power-on counts as battery insertion, so the button is probed first.
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= ST_PROBE;
         wake_cnt_ff <= {WAKE_W{1'b0}};
         from_ship_ff <= 1'b0;
      end else if (clk_en) begin
         state_ff <= nxt_state;
         if (nxt_state != ST_WAKE) begin
            wake_cnt_ff <= {WAKE_W{1'b0}};
         end else if (!wake_done) begin
            wake_cnt_ff <= wake_cnt_ff + {{(WAKE_W-1){1'b0}}, 1'b1};
         end
         if (state_ff != ST_WAKE) begin
            from_ship_ff <= (state_ff == ST_SHIP);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Battery protection and power-path outputs.

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bat_ok_ff <= 1'b0;
         ocp_ff <= 1'b0;
      end else if (clk_en) begin
         // The upper comparator sits 150 mV above the cutoff.
         if (!pin_ff[`COM_P_BAT_UV]) begin
            bat_ok_ff <= 1'b0;
         end else if (pin_ff[`COM_P_BAT_UV_HYS]) begin
            bat_ok_ff <= 1'b1;
         end
         // Latched until charge mode is entered; a new trip wins.
         if (pin_ff[`COM_P_BAT_OC] && bat_fet_ff) begin
            ocp_ff <= 1'b1;
         end else if (state_ff == ST_CHARGE) begin
            ocp_ff <= 1'b0;
         end
      end
   end

   wire batt_mode = (state_ff == ST_ACTBAT) || (state_ff == ST_LP);
   wire awake = is_clocked_mode(state_ff);

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bat_fet_ff <= 1'b0;
         sys_in_ff <= 1'b0;
         chg_ff <= 1'b0;
         vdd_en_ff <= 1'b0;
         vdd_bat_ff <= 1'b0;
         osc_ff <= 1'b1;
         ser_ff <= 1'b0;
         irq_en_ff <= 1'b0;
         aux_ff <= 1'b0;
      end else if (clk_en) begin
         bat_fet_ff <= ((batt_mode && bat_ok_ff) || state_ff == ST_CHARGE) && !ocp_ff;
         sys_in_ff <= (state_ff == ST_CHARGE) && pin_ff[`COM_P_IN_SLEEP] && !in_ovp;
         chg_ff <= (state_ff == ST_CHARGE) && pin_ff[`COM_P_IN_SLEEP] && !in_ovp &&
                   pin_ff[`COM_P_IN_DPM] && !pin_ff[`COM_P_CE_N] &&
                   !ctrl_ff[`COM_CTRL_CHG_DIS] && !charge_done;
         vdd_en_ff <= (state_ff != ST_SHIP);
         vdd_bat_ff <= (state_ff != ST_SHIP) && !in_uvlo_ok;
         osc_ff <= awake;
         ser_ff <= is_bus_mode(state_ff);
         irq_en_ff <= is_bus_mode(state_ff);
         aux_ff <= ctrl_ff[`COM_CTRL_AUX_EN] && (batt_mode || state_ff == ST_CHARGE);
      end
   end

   assign readdata = readdata_ff;
   assign waitrequest = waitreq_ff;
   assign mode = state_ff;
   assign vdd_enable = vdd_en_ff;
   assign vdd_from_battery = vdd_bat_ff;
   assign osc_enable = osc_ff;
   assign serial_enable = ser_ff;
   assign irq_enable = irq_en_ff;
   assign bat_fet_on = bat_fet_ff;
   assign system_rail_from_input = sys_in_ff;
   assign charge_active = chg_ff;
   assign aux_output_on = aux_ff;

endmodule // com_mode_ctrl

// [com_mode_ctrl_sva.sv]
module com_mode_sva (
   // Clock and reset.
   input wire clk,
   input wire rst_b,
   input wire clk_en,
   // Pins seen by the mode logic.
   input wire in_above_uvlo,
   input wire in_above_ovp,
   input wire bat_above_max_uvlo,
   input wire bat_overcurrent,
   // Mode and power outputs.
   input wire [2:0] mode,
   input wire vdd_enable,
   input wire vdd_from_battery,
   input wire osc_enable,
   input wire serial_enable,
   input wire irq_enable,
   input wire bat_fet_on,
   input wire system_rail_from_input,
   input wire charge_active
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // Outputs trail the mode by one edge, so gates look at the previous mode.
   property p_off_dark;
      mode == 3'h0 && $past(mode) == 3'h0 |-> !bat_fet_on && !vdd_enable && !serial_enable;
   endproperty
   a_off_dark: assert property (p_off_dark) else $error("latched-off output on");
   property p_serial_gate;
      serial_enable |-> $past(mode) inside {3'h2, 3'h3};
   endproperty
   a_serial_gate: assert property (p_serial_gate) else $error("serial on in bad mode");
   property p_irq_gate;
      irq_enable |-> $past(mode) inside {3'h2, 3'h3};
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq on in bad mode");
   property p_charge_gate;
      charge_active |-> $past(mode) == 3'h3;
   endproperty
   a_charge_gate: assert property (p_charge_gate) else $error("charging off charge mode");
   property p_rail_input;
      system_rail_from_input |-> $past(mode) == 3'h3;
   endproperty
   a_rail_input: assert property (p_rail_input) else $error("rail from input wrongly");
   property p_lp_quiet;
      mode == 3'h1 && $past(mode) == 3'h1 |-> !osc_enable && vdd_from_battery && !serial_enable;
   endproperty
   a_lp_quiet: assert property (p_lp_quiet) else $error("low power not quiet");
   property p_in_charge;
      (clk_en && in_above_uvlo && !in_above_ovp) [*8] |-> mode == 3'h3;
   endproperty
   a_in_charge: assert property (p_in_charge) else $error("valid input not charge mode");
   property p_ocp;
      (clk_en && bat_overcurrent && mode != 3'h3) [*8] |-> !bat_fet_on;
   endproperty
   a_ocp: assert property (p_ocp) else $error("fet on in overcurrent");
   property p_wake_gate;
      (clk_en && !bat_above_max_uvlo && mode == 3'h0) [*8] |=> mode != 3'h5;
   endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("wake with weak battery");
   c_lp: cover property (mode == 3'h1);
   c_wake: cover property (mode == 3'h0 ##1 mode == 3'h5);
   c_fet_off: cover property ($fell(bat_fet_on));
endmodule // com_mode_sva

bind com_mode_ctrl com_mode_sva chk_u (.clk, .rst_b, .clk_en, .in_above_uvlo, .in_above_ovp,
   .bat_above_max_uvlo, .bat_overcurrent, .mode, .vdd_enable, .vdd_from_battery,
   .osc_enable, .serial_enable, .irq_enable, .bat_fet_on, .system_rail_from_input,
   .charge_active);

// [com_host_model.sv]
module com_host_model (
   // Clock.
   input wire logic clk,
   // Avalon-MM master side.
   output logic [3:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // The request stands until waitrequest is seen low at a rising edge.
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Idle lines must not look like the last request.
      address <= ~a;
      writedata <= ~d;
   endtask
endmodule // com_host_model

// [tb_top.sv]
`include "com_consts.vh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PB = `COM_P_PB_N;
   localparam int LP = `COM_P_LP_N;
   localparam int BU = `COM_P_BAT_UV;
   localparam int BH = `COM_P_BAT_UV_HYS;
   localparam int BM = `COM_P_BAT_MAX;
   logic clk;
   logic rst_b;
   logic irq_pending;
   logic wdog_expired;
   logic [`COM_PIN_W-1:0] p;
   logic [3:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   wire [31:0] readdata;
   wire waitrequest;
   wire [2:0] mode;
   wire osc_enable;
   wire serial_enable;
   wire bat_fet_on;
   wire vdd_enable;
   wire vdd_from_battery;
   wire aux_output_on;
   wire irq_enable;
   wire system_rail_from_input;
   wire charge_active;
   logic clk_en;
   logic charge_done;
   logic [31:0] q;
   int n_fail;
   int comparisons;
   ////////////////////////////////////////
   com_mode_ctrl #(.WAKE_CYC(20)) dut_u (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
      .in_above_uvlo(p[`COM_P_IN_UVLO]), .in_above_ovp(p[`COM_P_IN_OVP]),
      .in_above_sleep(p[`COM_P_IN_SLEEP]), .in_above_dpm(p[`COM_P_IN_DPM]),
      .bat_above_uvlo(p[BU]), .bat_above_uvlo_hyst(p[BH]), .bat_above_max_uvlo(p[BM]),
      .bat_present(p[`COM_P_BAT_PRES]), .bat_overcurrent(p[`COM_P_BAT_OC]),
      .pushbutton_n(p[PB]), .low_power_select_n(p[LP]), .charge_enable_n(p[`COM_P_CE_N]),
      .charge_done(charge_done), .irq_pending(irq_pending), .wdog_expired(wdog_expired),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .mode(mode), .vdd_enable(vdd_enable),
      .vdd_from_battery(vdd_from_battery), .osc_enable(osc_enable),
      .serial_enable(serial_enable), .irq_enable(irq_enable), .bat_fet_on(bat_fet_on),
      .system_rail_from_input(system_rail_from_input), .charge_active(charge_active),
      .aux_output_on(aux_output_on));
   com_host_model host_u (.clk(clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a);
      host_u.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, q);
   endtask
   // Pins take four edges to filter, the mode one more and the outputs one more.
   task automatic pin(input int i, input logic v);
      p[i] <= v;
      step(10);
   endtask
   task automatic vin(input logic v);
      p[`COM_P_IN_UVLO] <= v;
      p[`COM_P_IN_SLEEP] <= v;
      p[`COM_P_IN_DPM] <= v;
      step(10);
   endtask
   task automatic results();
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      #(50 * 4000);
      n_fail++;
      results();
   end
   initial begin
      rst_b = 1'b0;
      irq_pending = 1'b0;
      wdog_expired = 1'b0;
      clk_en = 1'b1;
      charge_done = 1'b0;
      p = 12'hCF0;
      step(10);
      rst_b <= 1'b1;
      step(40);
      check("wake mode", mode, 32'h2);
      pin(PB, 1'b1);
      rd(`COM_STATUS_OFS);
      check("status", q, 32'h8A);
      rd(`COM_CTRL_OFS);
      check("ctrl", q, 32'h0);
      rd(4'h8);
      check("unmapped", q, 32'h0);
      wr(`COM_CTRL_OFS, 32'h2);
      irq_pending <= 1'b1;
      pin(LP, 1'b0);
      check("lp held", mode, 32'h2);
      irq_pending <= 1'b0;
      step(10);
      check("lp mode", mode, 32'h1);
      check("lp osc", {irq_enable, osc_enable, serial_enable, vdd_from_battery}, 32'h1);
      check("lp aux", aux_output_on, 32'h1);
      // A low clock enable must hold the mode even though the button moved.
      clk_en <= 1'b0;
      pin(PB, 1'b0);
      check("frozen", mode, 32'h1);
      clk_en <= 1'b1;
      step(10);
      check("lp press", mode, 32'h2);
      rd(`COM_STATUS_OFS);
      check("lp status", q, 32'h8A);
      pin(PB, 1'b1);
      check("lp back", mode, 32'h1);
      p[`COM_P_IN_OVP] <= 1'b1;
      vin(1'b1);
      check("ovp", mode, 32'h2);
      p[`COM_P_IN_OVP] <= 1'b0;
      vin(1'b0);
      check("ovp gone", mode, 32'h1);
      pin(LP, 1'b1);
      check("lp exit", mode, 32'h2);
      p[`COM_P_CE_N] <= 1'b0;
      vin(1'b1);
      rd(`COM_STATUS_OFS);
      check("chg status", q, 32'hBB);
      check("chg out", {system_rail_from_input, charge_active, irq_enable}, 32'h7);
      charge_done <= 1'b1;
      step(3);
      check("done", charge_active, 32'h0);
      charge_done <= 1'b0;
      wr(`COM_CTRL_OFS, 32'h3);
      step(10);
      check("defer", mode, 32'h3);
      wr(`COM_CTRL_OFS, 32'h2);
      vin(1'b0);
      check("cancel", mode, 32'h2);
      vin(1'b1);
      wr(`COM_CTRL_OFS, 32'h7);
      wdog_expired <= 1'b1;
      step(1);
      wdog_expired <= 1'b0;
      rd(`COM_CTRL_OFS);
      check("wdog ctrl", q, 32'h3);
      rd(`COM_STATUS_OFS);
      check("wdog status", q, 32'h1BB);
      p[PB] <= 1'b0;
      p[`COM_P_CE_N] <= 1'b1;
      vin(1'b0);
      check("pb wait", mode, 32'h2);
      pin(PB, 1'b1);
      check("off", mode, 32'h0);
      check("off out", {bat_fet_on, vdd_enable, serial_enable}, 32'h0);
      p[BM] <= 1'b0;
      pin(PB, 1'b0);
      step(30);
      pin(PB, 1'b1);
      check("weak wake", mode, 32'h0);
      p[BM] <= 1'b1;
      pin(PB, 1'b0);
      pin(PB, 1'b1);
      check("short", mode, 32'h0);
      pin(PB, 1'b0);
      step(30);
      pin(PB, 1'b1);
      check("wake", mode, 32'h2);
      p[BH] <= 1'b0;
      pin(BU, 1'b0);
      check("uv off", bat_fet_on, 32'h0);
      pin(BU, 1'b1);
      check("hys off", bat_fet_on, 32'h0);
      pin(BH, 1'b1);
      check("hys on", bat_fet_on, 32'h1);
      pin(`COM_P_BAT_OC, 1'b1);
      check("ocp", bat_fet_on, 32'h0);
      pin(`COM_P_BAT_PRES, 1'b0);
      pin(`COM_P_BAT_PRES, 1'b1);
      check("insert off", mode, 32'h0);
      results();
   end
endmodule // tb_top
